// File: fspg_pkg.sv
package fspg_pkg;
  // Clock and back-channel timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int BC_FRAME_BITS = 30;
  localparam int BC_BIT_NS_FAST = 20;
  localparam int BC_BIT_NS_SLOW = 400;
  localparam int BC_FRAME_NS_FAST = BC_FRAME_BITS * BC_BIT_NS_FAST;
  localparam int BC_FRAME_NS_SLOW = BC_FRAME_BITS * BC_BIT_NS_SLOW;
  localparam int TICK_CYC_FAST = (BC_FRAME_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CYC_SLOW = (BC_FRAME_NS_SLOW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 11;
  localparam logic [TICK_CNT_W-1:0] TICK_LIM_FAST = TICK_CNT_W'(TICK_CYC_FAST - 1);
  localparam logic [TICK_CNT_W-1:0] TICK_LIM_SLOW = TICK_CNT_W'(TICK_CYC_SLOW - 1);

  // Structure.
  localparam int NUM_PORTS = 4;
  localparam int SLOTS_PER_PORT = 4;
  localparam int NUM_GPIO = 8;

  // Register offsets.
  localparam logic [7:0] ADDR_CTL = 8'h18;
  localparam logic [7:0] ADDR_HI_U = 8'h19;
  localparam logic [7:0] ADDR_HI_L = 8'h1a;
  localparam logic [7:0] ADDR_LO_U = 8'h1b;
  localparam logic [7:0] ADDR_LO_L = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h1d;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] ADDR_RATE = 8'h58;
  localparam logic [7:0] ADDR_ROUTE_A = 8'h6e;
  localparam logic [7:0] ADDR_ROUTE_B = 8'h6f;

  // Field positions.
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_DUTY_BIT = 1;
  localparam int CTL_START_BIT = 2;
  localparam int CTL_SRC_LSB = 4;
  localparam int PSEL_RD_LSB = 4;
  localparam int ST_LEVEL_BIT = 0;
  localparam int ST_RUN_BIT = 1;

  // Encodings.
  localparam logic [2:0] RATE_50M = 3'h6;
  localparam logic [3:0] ROUTE_PULSE = 4'ha;
  localparam logic [3:0] ROUTE_HIGH = 4'h1;
  localparam logic [3:0] SRC_GPIO_FIRST = 4'h8;

  // Reset values.
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PSEL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
endpackage

// File: fspg_tick.sv
`timescale 1ns/1ps
module fspg_tick (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Rate.
  input wire logic rate_fast_in,
  // Tick.
  output logic tick_out
);
  import fspg_pkg::*;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic tick;
  } fspg_tick_s;

  fspg_tick_s st;
  fspg_tick_s next_st;
  logic [TICK_CNT_W-1:0] lim;

  always_comb begin
    next_st = st;
    lim = rate_fast_in ? TICK_LIM_FAST : TICK_LIM_SLOW;
    next_st.tick = 1'b0;
    // One tick per back-channel frame. [RQ6]
    if (st.cnt >= lim) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;
endmodule

// File: fspg_bc_port.sv
`timescale 1ns/1ps
module fspg_bc_port (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Register writes for this port.
  input wire logic wr_rate_in,
  input wire logic wr_route_a_in,
  input wire logic wr_route_b_in,
  input wire logic [7:0] wdata_in,
  // Pulse to forward.
  input wire logic pulse_in,
  // Register contents.
  output logic rate_fast_out,
  output logic [7:0] rate_sel_out,
  output logic [7:0] route_a_out,
  output logic [7:0] route_b_out,
  // Back-channel slots.
  output logic [fspg_pkg::SLOTS_PER_PORT-1:0] slot_out
);
  import fspg_pkg::*;

  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [SLOTS_PER_PORT-1:0] slot;
  } fspg_port_s;

  fspg_port_s st;
  fspg_port_s next_st;
  logic [3:0] sel;

  always_comb begin
    next_st = st;
    sel = 4'h0;
    if (wr_rate_in) begin
      next_st.rate = wdata_in;
    end
    if (wr_route_a_in) begin
      next_st.route_a = wdata_in;
    end
    if (wr_route_b_in) begin
      next_st.route_b = wdata_in;
    end
    // Every port registers the same pulse on the same edge, so skew is one clock at most. [RQ11]
    for (int i = 0; i < SLOTS_PER_PORT; i++) begin
      sel = (i < 2) ? st.route_a[4*(i%2) +: 4] : st.route_b[4*(i%2) +: 4];
      if (sel == ROUTE_PULSE) begin
        next_st.slot[i] = pulse_in; // [RQ2] [RQ13]
      end else begin
        next_st.slot[i] = (sel == ROUTE_HIGH);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st.rate <= RATE_RST;
      st.route_a <= ROUTE_RST;
      st.route_b <= ROUTE_RST;
      st.slot <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rate_fast_out = (st.rate[2:0] == RATE_50M); // [RQ12]
  assign rate_sel_out = st.rate;
  assign route_a_out = st.route_a;
  assign route_b_out = st.route_b;
  assign slot_out = st.slot;
endmodule

// File: fspg_top.sv
`timescale 1ns/1ps
// Function
// [RQ1] Source select 0x8..0xF with generator off forwards GPIO pin 0..7.
// [RQ2] Forward the frame pulse on slots whose port routing selects it.
// [RQ3] Control bit 0 set to 1 enables internal pulse generation.
// [RQ4] Enabled generator runs continuously on programmed counts until disabled.
// [RQ5] Source field bits 7:4 pick which port's back-channel tick clocks the generator.
// [RQ6] Tick is one 30-bit back-channel frame: 600 ns or 12 us.
// [RQ7] Control bit 1 picks 50/50 duty or separate high/low durations; 0 separate.
// [RQ8] Programmable mode: high for high count ticks, low for low count ticks.
// [RQ9] High and low counts are 16 bits, split into upper and lower bytes.
// [RQ10] Control bit 2 sets the starting level; 0 starts low.
// [RQ11] All four back channels carry the pulse synchronously with limited skew.
// [RQ12] Rate select pattern 110b sets a port to 50 Mbps, fixing its tick.
// [RQ13] Routing value 0xAA sends the pulse onto slots 0 and 1 of selected ports.
// [RQ14] In 50/50 mode the high count sets both halves; low count ignored.
// [RQ15] New counts apply at the next phase boundary, never truncating a phase.
module fspg_top (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Register port behind the serial control interface.
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // General-purpose pins.
  input wire logic [fspg_pkg::NUM_GPIO-1:0] gpio_in,
  // Frame pulse.
  output logic frame_pulse_out,
  output logic [fspg_pkg::NUM_PORTS*fspg_pkg::SLOTS_PER_PORT-1:0] backchannel_pin_slot_out
);
  import fspg_pkg::*;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] hi_u;
    logic [7:0] hi_l;
    logic [7:0] lo_u;
    logic [7:0] lo_l;
    logic [7:0] psel;
    logic [7:0] rdata;
    logic rvalid;
    logic running;
    logic level;
    logic [15:0] cnt;
    logic [15:0] len;
    logic pulse;
  } fspg_top_s;

  fspg_top_s st;
  fspg_top_s next_st;

  logic [NUM_PORTS-1:0] tick;
  logic [NUM_PORTS-1:0] rate_fast;
  logic [NUM_PORTS-1:0] wr_rate;
  logic [NUM_PORTS-1:0] wr_route_a;
  logic [NUM_PORTS-1:0] wr_route_b;
  logic [7:0] p_rate [NUM_PORTS];
  logic [7:0] p_route_a [NUM_PORTS];
  logic [7:0] p_route_b [NUM_PORTS];

  logic [3:0] src;
  logic gen_en;
  logic duty_even;
  logic start_level;
  logic [15:0] high_cnt;
  logic [15:0] low_cnt;
  logic [15:0] low_len;
  logic sel_tick;
  logic ext_pulse;
  logic [1:0] rd_port;
  logic [7:0] rd_mux;

  // Per-port writes follow the port mask in the low nibble of the port selector.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign wr_rate[p] = reg_wr_in && (reg_addr_in == ADDR_RATE) && st.psel[p];
    assign wr_route_a[p] = reg_wr_in && (reg_addr_in == ADDR_ROUTE_A) && st.psel[p];
    assign wr_route_b[p] = reg_wr_in && (reg_addr_in == ADDR_ROUTE_B) && st.psel[p];

    fspg_tick u_tick (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .rate_fast_in(rate_fast[p]),
      .tick_out(tick[p])
    );

    fspg_bc_port u_port (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .wr_rate_in(wr_rate[p]),
      .wr_route_a_in(wr_route_a[p]),
      .wr_route_b_in(wr_route_b[p]),
      .wdata_in(reg_wdata_in),
      .pulse_in(st.pulse),
      .rate_fast_out(rate_fast[p]),
      .rate_sel_out(p_rate[p]),
      .route_a_out(p_route_a[p]),
      .route_b_out(p_route_b[p]),
      .slot_out(backchannel_pin_slot_out[p*SLOTS_PER_PORT +: SLOTS_PER_PORT])
    );
  end

  always_comb begin
    next_st = st;
    src = st.ctl[CTL_SRC_LSB +: 4];
    gen_en = st.ctl[CTL_EN_BIT]; // [RQ3]
    duty_even = st.ctl[CTL_DUTY_BIT]; // [RQ7]
    start_level = st.ctl[CTL_START_BIT];
    high_cnt = {st.hi_u, st.hi_l}; // [RQ9]
    low_cnt = {st.lo_u, st.lo_l}; // [RQ9]
    low_len = duty_even ? high_cnt : low_cnt; // [RQ14]
    sel_tick = tick[src[1:0]]; // [RQ5]
    ext_pulse = (src >= SRC_GPIO_FIRST) ? gpio_in[src[2:0]] : 1'b0; // [RQ1]
    rd_port = st.psel[PSEL_RD_LSB +: 2];
    rd_mux = 8'h00;

    // Register writes.
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_CTL: begin
          next_st.ctl = reg_wdata_in;
        end
        ADDR_HI_U: begin
          next_st.hi_u = reg_wdata_in;
        end
        ADDR_HI_L: begin
          next_st.hi_l = reg_wdata_in;
        end
        ADDR_LO_U: begin
          next_st.lo_u = reg_wdata_in;
        end
        ADDR_LO_L: begin
          next_st.lo_l = reg_wdata_in;
        end
        ADDR_PORT_SEL: begin
          next_st.psel = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end

    // Register reads return the value held before any same-cycle write.
    case (reg_addr_in)
      ADDR_CTL: begin
        rd_mux = st.ctl;
      end
      ADDR_HI_U: begin
        rd_mux = st.hi_u;
      end
      ADDR_HI_L: begin
        rd_mux = st.hi_l;
      end
      ADDR_LO_U: begin
        rd_mux = st.lo_u;
      end
      ADDR_LO_L: begin
        rd_mux = st.lo_l;
      end
      ADDR_STATUS: begin
        rd_mux[ST_LEVEL_BIT] = st.level;
        rd_mux[ST_RUN_BIT] = st.running;
      end
      ADDR_PORT_SEL: begin
        rd_mux = st.psel;
      end
      ADDR_RATE: begin
        rd_mux = p_rate[rd_port];
      end
      ADDR_ROUTE_A: begin
        rd_mux = p_route_a[rd_port];
      end
      ADDR_ROUTE_B: begin
        rd_mux = p_route_b[rd_port];
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
    next_st.rvalid = reg_rd_in;
    if (reg_rd_in) begin
      next_st.rdata = rd_mux;
    end

    // Generator. The phase length is latched only at a boundary, so a write mid-phase waits.
    if (!gen_en) begin
      next_st.running = 1'b0;
      next_st.level = start_level;
      next_st.cnt = 16'h0000;
    end else if (!st.running) begin
      next_st.running = 1'b1;
      next_st.level = start_level; // [RQ10]
      next_st.cnt = 16'h0000;
      next_st.len = start_level ? high_cnt : low_len;
    end else if (sel_tick) begin
      // A zero count is treated as a one-tick phase rather than stalling the output.
      if (({1'b0, st.cnt} + 17'h00001) >= {1'b0, st.len}) begin
        next_st.level = ~st.level; // [RQ4] [RQ8]
        next_st.cnt = 16'h0000;
        next_st.len = st.level ? low_len : high_cnt; // [RQ15]
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end

    next_st.pulse = gen_en ? next_st.level : ext_pulse; // [RQ1] [RQ3]
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st.ctl <= CTL_RST;
      st.hi_u <= COUNT_RST;
      st.hi_l <= COUNT_RST;
      st.lo_u <= COUNT_RST;
      st.lo_l <= COUNT_RST;
      st.psel <= PSEL_RST;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
      st.running <= 1'b0;
      st.level <= 1'b0;
      st.cnt <= 16'h0000;
      st.len <= 16'h0000;
      st.pulse <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign reg_rvalid_out = st.rvalid;
  assign frame_pulse_out = st.pulse;
endmodule

// File: fspg_top_sva.sv
`timescale 1ns/1ps
module fspg_top_sva (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Register port.
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Pins.
  input wire logic [fspg_pkg::NUM_GPIO-1:0] gpio_in,
  input wire logic frame_pulse_out,
  input wire logic [fspg_pkg::NUM_PORTS*fspg_pkg::SLOTS_PER_PORT-1:0] backchannel_pin_slot_out
);
  import fspg_pkg::*;
  logic [7:0] ctl;
  logic [7:0] psel;
  logic [7:0] route0;
  // Shadows of the writes let the checker know the mode without peeking inside.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctl <= 8'h00;
      psel <= 8'h00;
      route0 <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CTL) ctl <= reg_wdata_in;
      if (reg_addr_in == ADDR_PORT_SEL) psel <= reg_wdata_in;
      if (reg_addr_in == ADDR_ROUTE_A && psel[0]) route0 <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
  rd_spurious_a: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("answer without read");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h30 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) srst_in |=> !reg_rvalid_out && !frame_pulse_out
    && backchannel_pin_slot_out == '0) else $error("outputs active in reset");
  ext_follow_a: assert property (ctl[7] && !ctl[0] && ctl == $past(ctl) |->
    frame_pulse_out == $past(gpio_in[ctl[6:4]])) else $error("pulse not from selected pin");
  slot_follow_a: assert property (route0 == 8'haa && $stable(route0) |->
    backchannel_pin_slot_out[0] == $past(frame_pulse_out)) else $error("slot not following pulse");
  slot_pair_a: assert property (route0 == 8'haa && $stable(route0) |->
    backchannel_pin_slot_out[1] == backchannel_pin_slot_out[0]) else $error("slots 0 and 1 differ");
  phase_min_a: assert property (ctl[0] && ctl == $past(ctl, 4) && $changed(frame_pulse_out) |=>
    $stable(frame_pulse_out)[*8]) else $error("phase shorter than a tick");
  status_run_a: assert property (reg_rd_in && reg_addr_in == ADDR_STATUS && ctl[0] && $past(ctl[0], 2)
    |=> reg_rdata_out[ST_RUN_BIT]) else $error("running flag low");
endmodule

// File: fspg_ser_model.sv
`timescale 1ns/1ps
module fspg_ser_model (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Back-channel slots.
  input wire logic [15:0] slot_in,
  // Rising edges seen on slot 0, a byte a port.
  output logic [31:0] rise_cnt_out
);
  logic [15:0] prev;
  always_ff @(posedge core_clk_in) begin
    prev <= slot_in;
    for (int p = 0; p < 4; p++) begin
      if (srst_in) rise_cnt_out[p*8+:8] <= 8'h00;
      else if (slot_in[p*4] && !prev[p*4]) rise_cnt_out[p*8+:8] <= rise_cnt_out[p*8+:8] + 8'h01;
    end
  end
endmodule

// File: fspg_top_tb.sv
`timescale 1ns/1ps
module fspg_top_tb;
  import fspg_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] gpio_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic frame_pulse_out;
  logic [15:0] slots;
  logic [31:0] rises;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  initial forever #5 core_clk_in = ~core_clk_in;
  fspg_top DUT (.core_clk_in(core_clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .gpio_in(gpio_in), .frame_pulse_out(frame_pulse_out),
    .backchannel_pin_slot_out(slots));
  fspg_ser_model u_ser (.core_clk_in(core_clk_in), .srst_in(srst_in), .slot_in(slots), .rise_cnt_out(rises));
  task test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    chk("rvalid", 1, reg_rvalid_out);
    chk("rdata", e, reg_rdata_out);
  endtask
  // Counts cycles until the pulse level changes; a missing edge ends the run.
  task phase(output int c);
    logic lvl;
    lvl = frame_pulse_out;
    c = 0;
    while (frame_pulse_out === lvl) begin
      @(negedge core_clk_in);
      c++;
      if (c > 20000) begin
        error_cnt++;
        $display("BAD phase exp edge got none");
        test_done();
      end
    end
  endtask
  task t_regs;
    for (int i = 0; i < 5; i++) rd(ADDR_CTL + 8'(i), 8'h00);
    rd(ADDR_RATE, 8'h00);
    for (int i = 1; i < 5; i++) wr(ADDR_CTL + 8'(i), 8'h50 + 8'(i));
    for (int i = 1; i < 5; i++) rd(ADDR_CTL + 8'(i), 8'h50 + 8'(i));
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    // Status is read-only, so a write must not disturb it.
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
  endtask
  // Neighbouring pins are set opposite so a wrong pin choice shows.
  task t_ext;
    wr(ADDR_PORT_SEL, 8'h0f);
    wr(ADDR_ROUTE_A, 8'haa);
    wr(ADDR_ROUTE_B, 8'h1a);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTL, {SRC_GPIO_FIRST + 4'(i), 4'h0});
      gpio_in = 8'h01 << i;
      repeat (3) @(negedge core_clk_in);
      chk("pulse high", 1, frame_pulse_out);
      chk("slots high", 16'hffff, slots);
      gpio_in = ~(8'h01 << i);
      repeat (3) @(negedge core_clk_in);
      chk("pulse low", 0, frame_pulse_out);
      chk("slots low", 16'h8888, slots);
    end
    gpio_in = 8'h00;
    chk("rises", 32'h08080808, rises);
  endtask
  task t_int;
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_RATE, 8'h5e);
    wr(ADDR_HI_U, 8'h00);
    wr(ADDR_HI_L, 8'h02);
    wr(ADDR_LO_U, 8'h01);
    wr(ADDR_LO_L, 8'h00);
    rd(ADDR_RATE, 8'h5e);
    wr(ADDR_CTL, 8'h01);
    @(negedge core_clk_in);
    chk("start low", 0, frame_pulse_out);
    phase(n);
    phase(n);
    chk("high", 2 * TICK_CYC_FAST, n);
    phase(n);
    chk("low", 256 * TICK_CYC_FAST, n);
    phase(n);
    chk("again high", 2 * TICK_CYC_FAST, n);
  endtask
  task t_duty;
    // The start level applies only when the generator comes up from off, so stop it first.
    wr(ADDR_CTL, 8'h00);
    wr(ADDR_CTL, 8'h07);
    @(negedge core_clk_in);
    chk("start high", 1, frame_pulse_out);
    rd(ADDR_STATUS, 8'h03);
    phase(n);
    phase(n);
    chk("duty low", 2 * TICK_CYC_FAST, n);
    wr(ADDR_HI_L, 8'h03);
    phase(n);
    chk("current high", 2 * TICK_CYC_FAST - 2, n);
    phase(n);
    chk("new low", 3 * TICK_CYC_FAST, n);
  endtask
  task t_port;
    wr(ADDR_CTL, 8'h13);
    phase(n);
    phase(n);
    chk("slow port", 3 * TICK_CYC_SLOW, n);
    wr(ADDR_CTL, 8'h00);
    gpio_in = 8'hff;
    repeat (200) @(negedge core_clk_in);
    chk("stopped", 0, frame_pulse_out);
    gpio_in = 8'h00;
    wr(ADDR_PORT_SEL, 8'h10);
    rd(ADDR_RATE, 8'h00);
    rd(ADDR_ROUTE_B, 8'h1a);
  endtask
  initial begin
    repeat (16) @(negedge core_clk_in);
    srst_in = 1'b0;
    t_regs();
    t_ext();
    t_int();
    t_duty();
    t_port();
    test_done();
  end
endmodule
bind fspg_top fspg_top_sva u_sva (.core_clk_in(core_clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .gpio_in(gpio_in),
  .frame_pulse_out(frame_pulse_out), .backchannel_pin_slot_out(backchannel_pin_slot_out));
